// >>> rts_cfg.svh
// Purpose: offsets, field positions, reset values and timing counts of the store
// Assumes: 10 MHz system clock
// Notes:   byte addresses on the register bus
`ifndef RTS_CFG_SVH
`define RTS_CFG_SVH

`define RTS_CLK_KHZ        10000
`define RTS_CIRC_NS        82030
`define RTS_CIRC_BITS      42
`define RTS_WORD_BITS      14
`define RTS_BIT_CYC        ((`RTS_CLK_KHZ * `RTS_CIRC_NS) / (1000000 * `RTS_CIRC_BITS))
`define RTS_RT_STEP_NS     246100
`define RTS_RT_CIRCS       (`RTS_RT_STEP_NS / `RTS_CIRC_NS)
`define RTS_CD_STEP_NS     492200
`define RTS_CD_CIRCS       (`RTS_CD_STEP_NS / `RTS_CIRC_NS)
`define RTS_MS_CIRCS       12

`define RTS_OFF_RTIME      8'h00
`define RTS_OFF_VEL1_B     8'h04
`define RTS_OFF_VEL1_C     8'h08
`define RTS_OFF_VEL2_B     8'h0c
`define RTS_OFF_VEL2_C     8'h10
`define RTS_OFF_VEL3_B     8'h14
`define RTS_OFF_VEL3_C     8'h18
`define RTS_OFF_MS_CD      8'h1c
`define RTS_OFF_SS_CD      8'h20
`define RTS_OFF_ML_CD      8'h24
`define RTS_OFF_INT_PEND   8'h28
`define RTS_OFF_INT_LIMIT  8'h2c
`define RTS_OFF_IN_REQ     8'h30

`define RTS_INT_SS         0
`define RTS_INT_ML         1
`define RTS_INT_EXT_LSB    2
`define RTS_WORD_RST       14'h0000
`define RTS_AXI_OKAY       2'b00
`define RTS_AXI_SLVERR     2'b10

`endif

// >>> rts_pkg.sv
// Purpose: types shared by the store and its serializer
// Assumes: nothing
// Notes:   channel and phase index the twelve word slots
package rts_pkg;
    typedef logic [13:0] word_t;
    typedef enum { CH_W, CH_X, CH_Y, CH_Z } chan_t;
    typedef enum { PH_A, PH_B, PH_C } phase_t;
    typedef enum { SER_IDLE, SER_WAIT_C, SER_SHIFT } ser_state_t;
endpackage : rts_pkg

// >>> ser_if.sv
// Purpose: load and shift link between store and serializer
// Assumes: one clock
// Notes:   bit_tick marks each bit time, one pulse every 19 clocks
`timescale 1ns/1ns
`default_nettype none
interface ser_if;
    import rts_pkg::*;
    logic  load;
    word_t word;
    logic  bit_tick;
    logic  busy;
    logic  sdata;
    logic  svalid;
    modport ctl (output load, output word, output bit_tick, input busy, input sdata, input svalid);
    modport ser (input load, input word, input bit_tick, output busy, output sdata, output svalid);
endinterface : ser_if
`default_nettype wire

// >>> serializer.sv
// Purpose: shift one parallel word out lsb first at the bit rate
// Assumes: load only while not busy
// Notes:   one bit per bit_tick
`timescale 1ns/1ns
`default_nettype none
module serializer
    import rts_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rstn_i,
    ser_if.ser        s
);
    word_t      sh_reg,  sh_next;
    logic [3:0] cnt_reg, cnt_next;
    logic       bit_reg, bit_next;
    logic       vld_reg, vld_next;

    always_comb begin
        sh_next  = sh_reg;
        cnt_next = cnt_reg;
        bit_next = bit_reg;
        vld_next = vld_reg;
        if (s.load && cnt_reg == 4'h0) begin
            sh_next  = s.word;
            cnt_next = 4'he;
        end else if (s.bit_tick) begin
            vld_next = (cnt_reg != 4'h0);
            bit_next = (cnt_reg != 4'h0) ? sh_reg[0] : 1'b0;
            if (cnt_reg != 4'h0) begin
                sh_next  = {1'b0, sh_reg[13:1]};
                cnt_next = cnt_reg - 4'h1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sh_reg  <= 14'h0000;
            cnt_reg <= 4'h0;
            bit_reg <= 1'b0;
            vld_reg <= 1'b0;
        end else begin
            sh_reg  <= sh_next;
            cnt_reg <= cnt_next;
            bit_reg <= bit_next;
            vld_reg <= vld_next;
        end
    end

    assign s.busy   = (cnt_reg != 4'h0);
    assign s.sdata  = bit_reg;
    assign s.svalid = vld_reg;
endmodule : serializer
`default_nettype wire

// >>> recirculating_timing_store.sv
// Purpose: triple-line recirculating word store with input serializer
// Assumes: AXI4-Lite master is the guidance computer's transfer path
// Notes:   word slots are modelled as flip-flops updated at slot passes and, for the delay count, on its bus write
`timescale 1ns/1ns
`default_nettype none
`include "rts_cfg.svh"
module recirculating_timing_store
    import rts_pkg::*;
#(
    parameter int VEL_INC_W = 4,
    parameter int N_EXT_INT = 11,
    parameter int N_IN      = 4
)(
    input  wire logic                   clk_i,
    input  wire logic                   rstn_i,
    input  wire logic [31:0]            s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [31:0]            s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    input  wire logic [6*VEL_INC_W-1:0] vel_inc_i,
    input  wire logic [N_EXT_INT-1:0]   int_src_i,
    input  wire logic [N_IN*14-1:0]     par_word_i,
    input  wire logic [13:0]            ground_word_i,
    input  wire logic [13:0]            cmd_rx_word_i,
    input  wire logic                   ground_connected_i,
    output logic                        irq_o,
    output logic                        dac_delay_done_o,
    output logic                        acc_serial_o,
    output logic                        acc_serial_valid_o
);
    localparam int NS = 12;
    localparam int NI = 2 + N_EXT_INT;

    // word slots per line, index chan*3 + phase
    word_t      mem_reg  [3][NS];
    word_t      mem_next [3][NS];
    logic [5:0] bit_reg,  bit_next;
    logic [4:0] cyc_reg,  cyc_next;
    logic [1:0] rtd_reg,  rtd_next;
    logic [2:0] cdd_reg,  cdd_next;
    logic       ms_run_reg, ms_run_next;
    logic       done_reg,   done_next;
    logic       irq_reg,    irq_next;
    logic       zss_reg,    zss_next;
    logic       ld_ss_reg,  ld_ss_next;
    logic       ld_ml_reg,  ld_ml_next;
    word_t      ld_ss_val_reg, ld_ss_val_next;
    word_t      ld_ml_val_reg, ld_ml_val_next;
    logic [NI-1:0] ack_reg, ack_next;
    // bus slave state
    logic       aw_rdy_reg, aw_rdy_next;
    logic       bv_reg,     bv_next;
    logic [1:0] br_reg,     br_next;
    logic       ar_rdy_reg, ar_rdy_next;
    logic       rv_reg,     rv_next;
    logic [1:0] rr_reg,     rr_next;
    logic [31:0] rd_reg,    rd_next;
    // input request state
    ser_state_t st_reg,     st_next;
    logic [3:0] sel_reg,    sel_next;
    logic       load_reg,   load_next;
    word_t      lword_reg,  lword_next;

    logic       tick;
    logic       slot_end;
    logic       circ_end;
    phase_t     ph;
    logic [7:0] waddr;
    logic [7:0] raddr;
    logic       wr_go;
    logic       rd_go;
    logic [NI-1:0] src;

    ser_if sif ();

    serializer u_ser (
        .clk_i  (clk_i),
        .rstn_i (rstn_i),
        .s      (sif.ser)
    );

    function automatic word_t maj(input word_t a, input word_t b, input word_t c);
        maj = (a & b) | (b & c) | (a & c);
    endfunction : maj

    function automatic word_t vel(input logic [1:0] ln, input phase_t p);
        vel = mem_reg[ln][int'(CH_Z) * 3 + int'(p)];
    endfunction : vel

    assign tick     = (cyc_reg == 5'(`RTS_BIT_CYC - 1));
    assign slot_end = tick && (bit_reg == 6'd13 || bit_reg == 6'd27 || bit_reg == 6'd41);
    assign circ_end = tick && (bit_reg == 6'(`RTS_CIRC_BITS - 1));
    assign ph       = (bit_reg < 6'd14) ? PH_A : (bit_reg < 6'd28) ? PH_B : PH_C;
    assign waddr    = s_axi_awaddr[7:0];
    assign raddr    = s_axi_araddr[7:0];
    assign wr_go    = aw_rdy_reg;
    assign rd_go    = ar_rdy_reg;
    assign src      = {int_src_i, 2'b00};

    assign sif.load     = load_reg;
    assign sif.word     = lword_reg;
    assign sif.bit_tick = tick;

    always_comb begin
        word_t w;
        word_t v;
        logic [NI-1:0] pend;
        logic [NI-1:0] lim;
        w = '0;
        v = '0;
        pend = '0;
        lim = '0;
        mem_next      = mem_reg;
        bit_next      = bit_reg;
        cyc_next      = tick ? 5'd0 : cyc_reg + 5'd1;
        rtd_next      = rtd_reg;
        cdd_next      = cdd_reg;
        ms_run_next   = ms_run_reg;
        done_next     = done_reg;
        zss_next      = zss_reg;
        ld_ss_next    = ld_ss_reg;
        ld_ml_next    = ld_ml_reg;
        ld_ss_val_next = ld_ss_val_reg;
        ld_ml_val_next = ld_ml_val_reg;
        ack_next      = ack_reg;
        aw_rdy_next   = 1'b0;
        bv_next       = bv_reg && !s_axi_bready;
        br_next       = br_reg;
        ar_rdy_next   = 1'b0;
        rv_next       = rv_reg && !s_axi_rready;
        rr_next       = rr_reg;
        rd_next       = rd_reg;
        st_next       = st_reg;
        sel_next      = sel_reg;
        load_next     = 1'b0;
        lword_next    = lword_reg;

        if (tick) begin
            bit_next = circ_end ? 6'd0 : bit_reg + 6'd1;
        end
        if (circ_end) begin
            rtd_next = (rtd_reg == 2'(`RTS_RT_CIRCS - 1)) ? 2'd0 : rtd_reg + 2'd1;
            cdd_next = (cdd_reg == 3'(`RTS_CD_CIRCS - 1)) ? 3'd0 : cdd_reg + 3'd1;
        end

        // channels Y and Z served in every slot pass, W and X in phase C only
        if (slot_end) begin
            unique case (ph)
                PH_A: begin
                    w = maj(mem_reg[0][9], mem_reg[1][9], mem_reg[2][9]);
                    if (rtd_reg == 2'd0) begin
                        w = w + 14'h0001;
                    end
                    for (int l = 0; l < 3; l++) mem_next[l][9] = w;
                    w = maj(mem_reg[0][6], mem_reg[1][6], mem_reg[2][6]);
                    if (ms_run_reg) begin
                        w = w - 14'h0001;
                        if (w == 14'h0000) begin
                            ms_run_next = 1'b0;
                            done_next   = 1'b1;
                        end
                    end
                    for (int l = 0; l < 3; l++) mem_next[l][6] = w;
                end
                PH_B, PH_C: begin
                    w = maj(mem_reg[0][6 + int'(ph)], mem_reg[1][6 + int'(ph)],
                            mem_reg[2][6 + int'(ph)]);
                    if (cdd_reg == 3'd0) begin
                        // interrupt on passing zero
                        // switch-selector word is already wrapped by phase C, so remember it
                        if (w == 14'h0000 && ph == PH_B) zss_next = 1'b1;
                        w = w - 14'h0001;
                    end
                    if (ph == PH_B && ld_ss_reg) begin
                        w = ld_ss_val_reg;
                        ld_ss_next = 1'b0;
                    end
                    if (ph == PH_C && ld_ml_reg) begin
                        w = ld_ml_val_reg;
                        ld_ml_next = 1'b0;
                    end
                    for (int l = 0; l < 3; l++) mem_next[l][6 + int'(ph)] = w;
                    for (int l = 0; l < 3; l++) begin
                        v = 14'(vel_inc_i[(ph == PH_B ? l : 3 + (l + 1) % 3) * VEL_INC_W
                                          +: VEL_INC_W]);
                        mem_next[l][9 + int'(ph)] = mem_reg[l][9 + int'(ph)] + v;
                    end
                end
            endcase
            if (ph == PH_C) begin
                pend = NI'(maj(mem_reg[0][2], mem_reg[1][2], mem_reg[2][2]));
                lim  = NI'(maj(mem_reg[0][5], mem_reg[1][5], mem_reg[2][5]));
                if (zss_reg) pend[`RTS_INT_SS] = 1'b1;
                zss_next = 1'b0;
                if (cdd_reg == 3'd0 && mem_reg[0][8] == 14'h0000) pend[`RTS_INT_ML] = 1'b1;
                pend = pend | (src & ~lim);
                lim  = (lim & src) | ack_reg;
                pend = pend & ~ack_reg;
                ack_next = '0;
                for (int l = 0; l < 3; l++) begin
                    mem_next[l][2] = 14'(pend);
                    mem_next[l][5] = 14'(lim);
                end
            end
        end

        // write channel: both address and data taken together
        if (s_axi_awvalid && s_axi_wvalid && !aw_rdy_reg && !bv_reg) begin
            aw_rdy_next = 1'b1;
        end
        if (wr_go) begin
            bv_next = 1'b1;
            br_next = `RTS_AXI_OKAY;
            unique case (waddr)
                `RTS_OFF_MS_CD: begin
                    for (int l = 0; l < 3; l++) mem_next[l][6] = 14'(`RTS_MS_CIRCS);
                    ms_run_next = 1'b1;
                    done_next   = 1'b0;
                end
                `RTS_OFF_SS_CD: begin
                    ld_ss_next     = 1'b1;
                    ld_ss_val_next = s_axi_wdata[13:0];
                end
                `RTS_OFF_ML_CD: begin
                    ld_ml_next     = 1'b1;
                    ld_ml_val_next = s_axi_wdata[13:0];
                end
                `RTS_OFF_INT_LIMIT: ack_next = ack_reg | s_axi_wdata[NI-1:0];
                `RTS_OFF_IN_REQ: begin
                    if (st_reg == SER_IDLE) begin
                        sel_next = s_axi_wdata[3:0];
                        st_next  = SER_WAIT_C;
                    end
                end
                default: br_next = `RTS_AXI_SLVERR;
            endcase
        end

        if (s_axi_arvalid && !ar_rdy_reg && !rv_reg) begin
            ar_rdy_next = 1'b1;
        end
        if (rd_go) begin
            rv_next = 1'b1;
            rr_next = `RTS_AXI_OKAY;
            rd_next = 32'h0000_0000;
            unique case (raddr)
                `RTS_OFF_RTIME:     rd_next = {18'h0, maj(mem_reg[0][9], mem_reg[1][9],
                                                          mem_reg[2][9])};
                // one sensor per phase word, no voting
                `RTS_OFF_VEL1_B:    rd_next = {18'h0, vel(2'd0, PH_B)};
                `RTS_OFF_VEL1_C:    rd_next = {18'h0, vel(2'd2, PH_C)};
                `RTS_OFF_VEL2_B:    rd_next = {18'h0, vel(2'd1, PH_B)};
                `RTS_OFF_VEL2_C:    rd_next = {18'h0, vel(2'd0, PH_C)};
                `RTS_OFF_VEL3_B:    rd_next = {18'h0, vel(2'd2, PH_B)};
                `RTS_OFF_VEL3_C:    rd_next = {18'h0, vel(2'd1, PH_C)};
                `RTS_OFF_MS_CD:     rd_next = {18'h0, mem_reg[0][6]};
                `RTS_OFF_SS_CD:     rd_next = {18'h0, mem_reg[0][7]};
                `RTS_OFF_ML_CD:     rd_next = {18'h0, mem_reg[0][8]};
                `RTS_OFF_INT_PEND:  rd_next = {18'h0, mem_reg[0][2]};
                `RTS_OFF_INT_LIMIT: rd_next = {18'h0, mem_reg[0][5]};
                `RTS_OFF_IN_REQ:    rd_next = {27'h0, sif.busy, sel_reg};
                default:            rr_next = `RTS_AXI_SLVERR;
            endcase
        end

        // serial word starts on a phase B boundary only
        // one selected word to the single serializer
        unique case (st_reg)
            SER_IDLE: ;
            SER_WAIT_C: begin
                if (tick && bit_reg == 6'd13) begin
                    load_next = 1'b1;
                    st_next   = SER_IDLE;
                    if (sel_reg == 4'h0) begin
                        // real time out in phase B
                        lword_next = maj(mem_reg[0][9], mem_reg[1][9], mem_reg[2][9]);
                    end else if (sel_reg == 4'h1) begin
                        // ground link gates out command receiver
                        lword_next = ground_connected_i ? ground_word_i : cmd_rx_word_i;
                    end else if (sel_reg < 4'(2 + N_IN)) begin
                        lword_next = par_word_i[(int'(sel_reg) - 2) * 14 +: 14];
                    end else begin
                        lword_next = 14'h0000;
                    end
                end
            end
            SER_SHIFT: st_next = SER_IDLE;
        endcase
        irq_next = (maj(mem_next[0][2], mem_next[1][2], mem_next[2][2]) != 14'h0000);
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            // slot contents are not initialised; flops cleared for sim only
            for (int l = 0; l < 3; l++) begin
                for (int i = 0; i < NS; i++) mem_reg[l][i] <= `RTS_WORD_RST;
            end
            bit_reg <= 6'd0;
            cyc_reg <= 5'd0;
            rtd_reg <= 2'd0;
            cdd_reg <= 3'd0;
            ms_run_reg <= 1'b0;
            done_reg   <= 1'b0;
            irq_reg    <= 1'b0;
            zss_reg    <= 1'b0;
            ld_ss_reg  <= 1'b0;
            ld_ml_reg  <= 1'b0;
            ld_ss_val_reg <= 14'h0000;
            ld_ml_val_reg <= 14'h0000;
            ack_reg    <= '0;
            aw_rdy_reg <= 1'b0;
            bv_reg     <= 1'b0;
            br_reg     <= 2'b00;
            ar_rdy_reg <= 1'b0;
            rv_reg     <= 1'b0;
            rr_reg     <= 2'b00;
            rd_reg     <= 32'h0000_0000;
            st_reg     <= SER_IDLE;
            sel_reg    <= 4'h0;
            load_reg   <= 1'b0;
            lword_reg  <= 14'h0000;
        end else begin
            mem_reg    <= mem_next;
            bit_reg    <= bit_next;
            cyc_reg    <= cyc_next;
            rtd_reg    <= rtd_next;
            cdd_reg    <= cdd_next;
            ms_run_reg <= ms_run_next;
            done_reg   <= done_next;
            irq_reg    <= irq_next;
            zss_reg    <= zss_next;
            ld_ss_reg  <= ld_ss_next;
            ld_ml_reg  <= ld_ml_next;
            ld_ss_val_reg <= ld_ss_val_next;
            ld_ml_val_reg <= ld_ml_val_next;
            ack_reg    <= ack_next;
            aw_rdy_reg <= aw_rdy_next;
            bv_reg     <= bv_next;
            br_reg     <= br_next;
            ar_rdy_reg <= ar_rdy_next;
            rv_reg     <= rv_next;
            rr_reg     <= rr_next;
            rd_reg     <= rd_next;
            st_reg     <= st_next;
            sel_reg    <= sel_next;
            load_reg   <= load_next;
            lword_reg  <= lword_next;
        end
    end

    // velocity lsb is 0.05 m/s; counts are raw
    assign s_axi_awready      = aw_rdy_reg;
    assign s_axi_wready       = aw_rdy_reg;
    assign s_axi_bvalid       = bv_reg;
    assign s_axi_bresp        = br_reg;
    assign s_axi_arready      = ar_rdy_reg;
    assign s_axi_rvalid       = rv_reg;
    assign s_axi_rresp        = rr_reg;
    assign s_axi_rdata        = rd_reg;
    assign irq_o              = irq_reg;
    assign dac_delay_done_o   = done_reg;
    assign acc_serial_o       = sif.sdata;
    assign acc_serial_valid_o = sif.svalid;
endmodule : recirculating_timing_store
`default_nettype wire

// >>> rts_assertions.sv
// Purpose: bus handshake and serial frame checks on the store's ports
// Assumes: sees only top-level ports
// Notes:   each serial bit lasts 19 clocks, so 8 is a safe lower bound
`timescale 1ns/1ns
`default_nettype none
module rts_assertions (
    input wire logic        clk_i,
    input wire logic        rstn_i,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        acc_serial_valid_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    sequence bit_s;
        acc_serial_valid_o [*8];
    endsequence
    sequence b_wait_s;
        s_axi_bvalid && !s_axi_bready;
    endsequence
    chk_aw_w_pair: assert property (s_axi_awready |-> s_axi_wready)
        else $error("write address and data not taken together");
    chk_b_follows: assert property (s_axi_awready |=> s_axi_bvalid)
        else $error("write response late");
    chk_b_hold: assert property (b_wait_s |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before bready");
    chk_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response held after handshake");
    chk_r_follows: assert property (s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read data changed before rready");
    chk_ar_pulse: assert property (s_axi_arready |=> !s_axi_arready)
        else $error("read address ready held");
    chk_resp_code: assert property (s_axi_rvalid |-> s_axi_rresp inside {2'b00, 2'b10})
        else $error("bad read response code");
    chk_serial_bit: assert property ($rose(acc_serial_valid_o) |-> bit_s)
        else $error("serial bit too short");
endmodule : rts_assertions
bind recirculating_timing_store rts_assertions chk_u (.*);
`default_nettype wire

// >>> cpu_model.sv
// Purpose: guidance computer side, an axi4-lite master
// Assumes: one write and one read at most under way
// Notes:   no answer latency assumed, the bench watchdog ends a hang
`timescale 1ns/1ns
`default_nettype none
module cpu_model (
    input  wire logic        clk_i,
    output logic [31:0]      awaddr_o,
    output logic             awvalid_o,
    input  wire logic        awready_i,
    output logic [31:0]      wdata_o,
    output logic             wvalid_o,
    input  wire logic        wready_i,
    input  wire logic [1:0]  bresp_i,
    input  wire logic        bvalid_i,
    output logic             bready_o,
    output logic [31:0]      araddr_o,
    output logic             arvalid_o,
    input  wire logic        arready_i,
    input  wire logic [31:0] rdata_i,
    input  wire logic [1:0]  rresp_i,
    input  wire logic        rvalid_i,
    output logic             rready_o
);
    initial begin
        {awaddr_o, awvalid_o, wdata_o, wvalid_o, bready_o} = '0;
        {araddr_o, arvalid_o, rready_o} = '0;
    end
    task automatic wr(input logic [31:0] a, input logic [31:0] v, output logic [1:0] r);
        @(posedge clk_i);
        awaddr_o  <= a;
        wdata_o   <= v;
        awvalid_o <= 1'b1;
        wvalid_o  <= 1'b1;
        bready_o  <= 1'b1;
        do begin
            @(posedge clk_i);
            if (awready_i) awvalid_o <= 1'b0;
            if (wready_i) wvalid_o <= 1'b0;
        end while (!bvalid_i);
        r = bresp_i;
        bready_o <= 1'b0;
    endtask : wr
    task automatic rd(input logic [31:0] a, output logic [31:0] v, output logic [1:0] r);
        @(posedge clk_i);
        araddr_o  <= a;
        arvalid_o <= 1'b1;
        rready_o  <= 1'b1;
        do begin
            @(posedge clk_i);
            if (arready_i) arvalid_o <= 1'b0;
        end while (!rvalid_i);
        v = rdata_i;
        r = rresp_i;
        rready_o <= 1'b0;
    endtask : rd
endmodule : cpu_model
`default_nettype wire

// >>> recirculating_timing_store_tb.sv
// Purpose: self-checking bench for the recirculating store
// Assumes: 10 MHz clock, cpu_model as bus master
// Notes:   words start undefined, so real time and velocity reads compare differences only
`timescale 1ns/1ns
`default_nettype none
module recirculating_timing_store_tb;
    import rts_pkg::*;
    localparam int CIRC = 798;
    logic clk_i = 0, rstn_i = 0, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic irq_o, dac_delay_done_o, acc_serial_o, acc_serial_valid_o, ground_connected_i = 0;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, d0, d;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic [23:0] vel_inc_i = '0;
    logic [10:0] int_src_i = '0;
    logic [55:0] par_word_i = '0;
    logic [13:0] ground_word_i = '0, cmd_rx_word_i = '0, sw;
    int          cyc = 0, n, checked = 0, num_errors = 0;
    int          idx [6] = '{0, 3, 1, 4, 2, 5};
    word_t       exp_q [$];
    recirculating_timing_store dut_u (.*);
    cpu_model cpu (.clk_i, .awaddr_o(s_axi_awaddr), .awvalid_o(s_axi_awvalid),
        .awready_i(s_axi_awready), .wdata_o(s_axi_wdata), .wvalid_o(s_axi_wvalid),
        .wready_i(s_axi_wready), .bresp_i(s_axi_bresp), .bvalid_i(s_axi_bvalid),
        .bready_o(s_axi_bready), .araddr_o(s_axi_araddr), .arvalid_o(s_axi_arvalid),
        .arready_i(s_axi_arready), .rdata_i(s_axi_rdata), .rresp_i(s_axi_rresp),
        .rvalid_i(s_axi_rvalid), .rready_o(s_axi_rready));
    always #50 clk_i = ~clk_i;
    always @(posedge clk_i) cyc <= cyc + 1;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask : chk
    task automatic conclude();
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : conclude
    // a fixed start cycle for each read keeps their spacing exact
    task automatic rd_at(input int t, input logic [31:0] a, output logic [31:0] v);
        wait (cyc == t);
        cpu.rd(a, v, r);
    endtask : rd_at
    task automatic wait_for(input bit dac, input int lim);
        n = 0;
        while ((dac ? dac_delay_done_o : irq_o) !== 1'b1 && n < lim) begin
            @(posedge clk_i);
            n++;
        end
    endtask : wait_for
    // word leaves in phase B; sample mid-bit on the falling edge
    always begin
        @(posedge acc_serial_valid_o);
        repeat (9) @(negedge clk_i);
        for (int b = 0; b < 14; b++) begin
            sw[b] = acc_serial_o;
            repeat (19) @(negedge clk_i);
        end
        chk(sw, exp_q.size() ? exp_q.pop_front() : ~sw);
    end
    initial begin
        repeat (90000) @(posedge clk_i);
        num_errors++;
        conclude();
    end
    initial begin
        void'($urandom(32'h3b1291e9));
        repeat (4) @(posedge clk_i);
        rstn_i <= 1'b1;
        cpu.wr(32'h24, 32'h3fff, r);
        cpu.wr(32'h20, 32'h3fff, r);
        chk(r, 2'b00);
        cpu.wr(32'h00, 32'h1, r);
        chk(r, 2'b10);
        cpu.rd(32'h40, d, r);
        chk({d[29:0], r}, 32'h2);
        $display("test refusals done");
        n = cyc + 2;
        rd_at(n, 32'h00, d0);
        rd_at(n + 12 * CIRC, 32'h00, d);
        chk((d - d0) & 32'h3fff, 32'h4);
        $display("test real time done");
        for (int k = 0; k < 6; k++) begin
            vel_inc_i <= 24'($urandom);
            n = cyc + 3;
            rd_at(n, 32'(4 * (k + 1)), d0);
            rd_at(n + 5 * CIRC, 32'(4 * (k + 1)), d);
            chk((d - d0) & 32'h3fff, 32'((5 * vel_inc_i[idx[k] * 4 +: 4]) & 14'h3fff));
        end
        $display("test velocity done");
        cpu.wr(32'h2c, 32'h3, r);
        repeat (2 * CIRC) @(posedge clk_i);
        cpu.rd(32'h28, d, r);
        chk(d, 32'h0);
        cpu.wr(32'h20, 32'h2, r);
        wait_for(0, 20 * CIRC);
        chk(n > 11 * CIRC && n < 20 * CIRC, 1);
        cpu.rd(32'h28, d, r);
        chk(d, 32'h1);
        cpu.wr(32'h2c, 32'h1, r);
        repeat (2 * CIRC) @(posedge clk_i);
        chk(irq_o, 1'b0);
        $display("test countdown done");
        cpu.wr(32'h1c, 32'h1, r);
        wait_for(1, 14 * CIRC);
        chk(n > 10 * CIRC && n < 14 * CIRC, 1);
        $display("test delay done");
        for (int k = 0; k < 4; k++) begin
            ground_connected_i <= k[0];
            ground_word_i <= 14'($urandom);
            cmd_rx_word_i <= 14'($urandom);
            par_word_i <= 56'({$urandom, $urandom});
            @(posedge clk_i);
            exp_q.push_back(k < 2 ? (k[0] ? ground_word_i : cmd_rx_word_i)
                                  : par_word_i[(k - 2) * 14 +: 14]);
            cpu.wr(32'h30, k < 2 ? 32'h1 : 32'(k), r);
            repeat (3 * CIRC) @(posedge clk_i);
        end
        chk(exp_q.size(), 0);
        $display("test serializer done");
        conclude();
    end
endmodule : recirculating_timing_store_tb
`default_nettype wire
